// [hdl/drt_map.svh]
// offsets, field positions and reset values of the dual reload countdown timer
//
// Operation
// - two independent units, alike but for unit one's comparator source, each hold a reload period register and a separate running count register.
// - when a running count is at 0x0000 the next tick loads the reload period and counting goes on from it.
// - each unit's reload event raises its own request, first_unit_irq for unit one, second_unit_irq for unit two.
// - first_unit_irq ranks second-highest and second_unit_irq third-highest among the device's interrupts.
// - the four 16-bit registers are read/write I/O ports at 0x3A, 0x3B, 0x3E and 0x3F.
// - reading a reload or running count register returns its present contents at any moment.
// - writing a reload period leaves the running count alone until it reaches 0x0000 and reloads.
// - with the comparator enable set, unit one counts comparator events instead of its clock source.
// - writing a running count also writes the reload period and counting continues at once from the new value.
// - general control bit 8 picks unit one's source and bit 9 unit two's; clear is half master clock, set is reference.
// - general control bits 10 and 11 enable the units; clearing holds the count, setting resumes from it.
// - the maximum count and zero each last one full source tick, so underflows are reload value plus one apart.
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH

`define DRT_ADDR_W          8
`define DRT_GEN_CTRL_ADDR   8'h38
`define DRT_U1_PERIOD_ADDR  8'h3A
`define DRT_U1_COUNT_ADDR   8'h3B
`define DRT_U2_PERIOD_ADDR  8'h3E
`define DRT_U2_COUNT_ADDR   8'h3F
`define DRT_SRC_SEL_BIT     8
`define DRT_ENABLE_BIT      10
`define DRT_COUNT_ZERO      16'h0000
`define DRT_REG_RESET       16'h0000
`define DRT_RANK_NONE       2'h0
`define DRT_RANK_FIRST      2'h2
`define DRT_RANK_SECOND     2'h3

`endif

// [hdl/drt_pkg.sv]
// types of the dual reload countdown timer
`default_nettype none

package drt_pkg;
    typedef enum {DRT_SRC_HALF_MC, DRT_SRC_REF, DRT_SRC_COMP} drt_src_t;
    typedef logic [1:0] drt_rank_t;
endpackage

`default_nettype wire

// [hdl/drt_timer.sv]
// two reload countdown units with their I/O register port
`include "drt_map.svh"
`default_nettype none

module drt_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire logic [`DRT_ADDR_W-1:0]  IO_ADDR,
    input  wire logic [WIDTH-1:0]        IO_WDATA,
    input  wire logic                    IO_WR,
    input  wire logic                    IO_RD,
    output logic      [WIDTH-1:0]        IO_RDATA,
    input  wire logic                    REF_OSC,
    input  wire logic                    COMP_ENABLE,
    input  wire logic                    COMP_TICK,
    output logic                         FIRST_UNIT_IRQ,
    output logic                         SECOND_UNIT_IRQ,
    output drt_pkg::drt_rank_t           IRQ_RANK
);
    import drt_pkg::*;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (WIDTH < 12 || WIDTH > 32)
    begin : g_width_check
        $error("drt_timer: WIDTH must lie between 12 and 32");
    end

    localparam logic [`DRT_ADDR_W-1:0] PERIOD_ADDR [2] = '{`DRT_U1_PERIOD_ADDR, `DRT_U2_PERIOD_ADDR};
    localparam logic [`DRT_ADDR_W-1:0] COUNT_ADDR  [2] = '{`DRT_U1_COUNT_ADDR, `DRT_U2_COUNT_ADDR};
    localparam logic [WIDTH-1:0]       ZERO        = WIDTH'(`DRT_COUNT_ZERO);
    localparam logic [WIDTH-1:0]       RESET_VAL   = WIDTH'(`DRT_REG_RESET);

    // ----------------------------------------------------------------
    // tick sources
    // ----------------------------------------------------------------
    logic       half_reg;
    logic       half_next;
    logic [2:0] ref_sync_reg;
    logic [2:0] ref_sync_next;
    logic       ref_lvl_reg;
    logic       ref_lvl_next;
    logic       ref_tick;
    logic       half_tick;

    always_comb
    begin
        half_next     = ~half_reg;
        ref_sync_next = {ref_sync_reg[1:0], REF_OSC};
        ref_lvl_next  = ref_lvl_reg;
        if (ref_sync_reg[1] == ref_sync_reg[2])
        begin
            ref_lvl_next = ref_sync_reg[2];
        end
        half_tick = half_reg;
        ref_tick  = ref_lvl_next & ~ref_lvl_reg;
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            half_reg     <= 1'b0;
            ref_sync_reg <= 3'h0;
            ref_lvl_reg  <= 1'b0;
        end
        else
        begin
            half_reg     <= half_next;
            ref_sync_reg <= ref_sync_next;
            ref_lvl_reg  <= ref_lvl_next;
        end
    end

    // ----------------------------------------------------------------
    // general control register
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] gen_ctrl_reg;
    logic [WIDTH-1:0] gen_ctrl_next;
    logic [1:0]       src_sel;
    logic [1:0]       unit_en;

    always_comb
    begin
        gen_ctrl_next = gen_ctrl_reg;
        if (IO_WR && IO_ADDR == `DRT_GEN_CTRL_ADDR)
        begin
            gen_ctrl_next = IO_WDATA;
        end
        src_sel = gen_ctrl_reg[`DRT_SRC_SEL_BIT +: 2];
        unit_en = gen_ctrl_reg[`DRT_ENABLE_BIT +: 2];
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            gen_ctrl_reg <= RESET_VAL;
        end
        else
        begin
            gen_ctrl_reg <= gen_ctrl_next;
        end
    end

    // ----------------------------------------------------------------
    // counting units
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] period_reg  [2];
    logic [WIDTH-1:0] period_next [2];
    logic [WIDTH-1:0] count_reg   [2];
    logic [WIDTH-1:0] count_next  [2];
    logic [1:0]       irq_reg;
    logic [1:0]       irq_next;
    logic [1:0]       tick;
    logic [1:0]       run;
    logic [1:0]       wr_period;
    logic [1:0]       wr_count;
    drt_src_t         src [2];

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            src[i] = src_sel[i] ? DRT_SRC_REF : DRT_SRC_HALF_MC;
            if (i == 0 && COMP_ENABLE)
            begin
                src[i] = DRT_SRC_COMP;
            end
            case (src[i])
                DRT_SRC_HALF_MC: tick[i] = half_tick;
                DRT_SRC_REF:     tick[i] = ref_tick;
                DRT_SRC_COMP:    tick[i] = COMP_TICK;
                default:         tick[i] = 1'b0;
            endcase
            run[i]         = tick[i] & unit_en[i];
            wr_period[i]   = IO_WR && IO_ADDR == PERIOD_ADDR[i];
            wr_count[i]    = IO_WR && IO_ADDR == COUNT_ADDR[i];
            period_next[i] = period_reg[i];
            count_next[i]  = count_reg[i];
            irq_next[i]    = 1'b0;
            if (wr_count[i])
            begin
                count_next[i]  = IO_WDATA;
                period_next[i] = IO_WDATA;
            end
            else
            begin
                if (wr_period[i])
                begin
                    period_next[i] = IO_WDATA;
                end
                if (run[i])
                begin
                    if (count_reg[i] == ZERO)
                    begin
                        count_next[i] = period_reg[i];
                        irq_next[i]   = 1'b1;
                    end
                    else
                    begin
                        count_next[i] = count_reg[i] - 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < 2; i++)
            begin
                period_reg[i] <= RESET_VAL;
                count_reg[i]  <= RESET_VAL;
            end
            irq_reg <= 2'b00;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                period_reg[i] <= period_next[i];
                count_reg[i]  <= count_next[i];
            end
            irq_reg <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // request outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        FIRST_UNIT_IRQ  = irq_reg[0];
        SECOND_UNIT_IRQ = irq_reg[1];
        if (irq_reg[0])
        begin
            IRQ_RANK = `DRT_RANK_FIRST;
        end
        else if (irq_reg[1])
        begin
            IRQ_RANK = `DRT_RANK_SECOND;
        end
        else
        begin
            IRQ_RANK = `DRT_RANK_NONE;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] rdata_reg;
    logic [WIDTH-1:0] rdata_next;

    always_comb
    begin
        rdata_next = rdata_reg;
        if (IO_RD)
        begin
            case (IO_ADDR)
                `DRT_GEN_CTRL_ADDR:  rdata_next = gen_ctrl_reg;
                `DRT_U1_PERIOD_ADDR: rdata_next = period_reg[0];
                `DRT_U1_COUNT_ADDR:  rdata_next = count_reg[0];
                `DRT_U2_PERIOD_ADDR: rdata_next = period_reg[1];
                `DRT_U2_COUNT_ADDR:  rdata_next = count_reg[1];
                default:             rdata_next = ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rdata_reg <= RESET_VAL;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign IO_RDATA = rdata_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    for (genvar g = 0; g < 2; g++)
    begin : g_chk
        sequence reload_cause;
            run[g] && !wr_count[g] && count_reg[g] == ZERO;
        endsequence

        reload_from_period_a : assert property (reload_cause |=> count_reg[g] == $past(period_reg[g]))
            else $error("count did not reload from period");
        step_down_one_a : assert property (run[g] && !wr_count[g] && count_reg[g] != ZERO
                                           |=> count_reg[g] == $past(count_reg[g]) - 1'b1)
            else $error("count did not step down by one");
        irq_on_reload_a : assert property (irq_reg[g] == $past(run[g] && !wr_count[g] && count_reg[g] == ZERO))
            else $error("request not tied to reload");
        hold_when_off_a : assert property (!unit_en[g] && !wr_count[g] |=> $stable(count_reg[g]))
            else $error("count moved while disabled");
        count_write_both_a : assert property (wr_count[g] |=> count_reg[g] == $past(IO_WDATA)
                                              && period_reg[g] == $past(IO_WDATA))
            else $error("count write did not set both registers");
        period_write_late_a : assert property (wr_period[g] && count_reg[g] != ZERO
                                               |=> count_reg[g] == $past(count_reg[g])
                                               || count_reg[g] == $past(count_reg[g]) - 1'b1)
            else $error("period write disturbed count");
        reload_gap_a : assert property (reload_cause ##1 (!wr_count[g] && !wr_period[g] && period_reg[g] == ZERO)
                                        ##0 run[g] |-> ##1 irq_reg[g])
            else $error("zero period did not underflow on next tick");
    end

    half_source_a : assert property (!src_sel[1] |-> tick[1] == half_reg)
        else $error("second unit not on half master clock");
    comp_source_a : assert property (COMP_ENABLE |-> tick[0] == COMP_TICK)
        else $error("first unit not on comparator");
    rank_first_a : assert property (irq_reg[0] |-> IRQ_RANK == `DRT_RANK_FIRST)
        else $error("first unit rank wrong");
    rank_second_a : assert property (irq_reg[1] && !irq_reg[0] |-> IRQ_RANK == `DRT_RANK_SECOND)
        else $error("second unit rank wrong");
    read_count_a : assert property (IO_RD && IO_ADDR == `DRT_U1_COUNT_ADDR |=> IO_RDATA == $past(count_reg[0]))
        else $error("count read back wrong");
    read_period_a : assert property (IO_RD && IO_ADDR == `DRT_U2_PERIOD_ADDR
                                     |=> IO_RDATA == $past(period_reg[1]))
        else $error("period read back wrong");

endmodule

`default_nettype wire

// [tb/drt_core_model.sv]
// processor core model issuing port-addressed I/O cycles to the timer
`include "drt_map.svh"
`default_nettype none

module drt_core_model (
    input  wire logic                   CLK,
    output logic [`DRT_ADDR_W-1:0]      IO_ADDR,
    output logic [15:0]                 IO_WDATA,
    output logic                        IO_WR,
    output logic                        IO_RD,
    input  wire logic [15:0]            IO_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        IO_ADDR = 8'h00;
        IO_WDATA = 16'h0000;
        IO_WR = 1'b0;
        IO_RD = 1'b0;
    end

    // one-cycle write strobe; released lines show the inverse of their last value
    task automatic io_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK);
        IO_ADDR <= a;
        IO_WDATA <= d;
        IO_WR <= 1'b1;
        @(posedge CLK);
        IO_WR <= 1'b0;
        IO_ADDR <= ~a;
        IO_WDATA <= ~d;
    endtask

    // one-cycle read strobe; data is registered on the edge that takes it
    task automatic io_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK);
        IO_ADDR <= a;
        IO_RD <= 1'b1;
        @(posedge CLK);
        IO_RD <= 1'b0;
        IO_ADDR <= ~a;
        @(negedge CLK);
        d = IO_RDATA;
    endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// self-checking testbench of the dual reload countdown timer
`include "drt_map.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] wa; logic [15:0] wd; logic [7:0] ra; logic [15:0] exp;} drt_row_t;
    logic [`DRT_ADDR_W-1:0] io_addr;
    logic [15:0]            io_wdata, io_rdata, rd, io_hold;
    logic                   clk, rst_n, io_wr, io_rd, comp_enable, comp_tick;
    logic                   ref_osc = 1'b0;
    logic                   first_irq, second_irq;
    drt_pkg::drt_rank_t     irq_rank;
    int                     failures, checks_done, n, w;
    int                     cycles = 0;
    logic [3:0]             ref_div = 4'h0;
    drt_row_t               rows [8];

    drt_timer #(.WIDTH(16)) i_drt_timer (.CLK(clk), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
        .IO_WR(io_wr), .IO_RD(io_rd), .IO_RDATA(io_rdata), .REF_OSC(ref_osc), .COMP_ENABLE(comp_enable),
        .COMP_TICK(comp_tick), .FIRST_UNIT_IRQ(first_irq), .SECOND_UNIT_IRQ(second_irq), .IRQ_RANK(irq_rank));
    drt_core_model i_drt_core_model (.CLK(clk), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_WR(io_wr),
        .IO_RD(io_rd), .IO_RDATA(io_rdata));

    // ----------------------------------------
    // clock, reference oscillator, timeout
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        ref_div <= (ref_div == 4'h4) ? 4'h0 : ref_div + 4'h1;
        ref_osc <= (ref_div == 4'h4) ? ~ref_osc : ref_osc;
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // all registers read back zero after reset
    task automatic check_zero;
        logic [7:0] addrs [5];
        addrs = '{8'h38, 8'h3A, 8'h3B, 8'h3E, 8'h3F};
        foreach (addrs[i])
        begin
            i_drt_core_model.io_read(addrs[i], rd);
            check("reset value", rd, 16'h0000);
        end
    endtask

    // waits for a pulse of unit u, then counts cycles to its next pulse
    task automatic gap(input bit u, input logic [1:0] rank, output int wt, output int len);
        wt = 0;
        len = 0;
        do begin @(posedge clk); #1; wt++; end while ((u ? second_irq : first_irq) !== 1'b1 && wt < 400);
        check("irq rank", {14'h0, irq_rank}, {14'h0, rank});
        do begin @(posedge clk); #1; len++; end while ((u ? second_irq : first_irq) !== 1'b1 && len < 400);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        comp_enable = 1'b0;
        comp_tick = 1'b0;
        failures = 0;
        checks_done = 0;
        rows = '{'{8'h3A, 16'h1234, 8'h3A, 16'h1234}, '{8'h3B, 16'h00C3, 8'h3A, 16'h00C3},
                 '{8'h3A, 16'h0077, 8'h3B, 16'h00C3}, '{8'h3E, 16'hABCD, 8'h3E, 16'hABCD},
                 '{8'h3F, 16'h5A5A, 8'h3E, 16'h5A5A}, '{8'h38, 16'h0300, 8'h38, 16'h0300},
                 '{8'h38, 16'h0000, 8'h38, 16'h0000}, '{8'h39, 16'hFFFF, 8'h39, 16'h0000}};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        check_zero();
        foreach (rows[i])
        begin
            i_drt_core_model.io_write(rows[i].wa, rows[i].wd);
            i_drt_core_model.io_read(rows[i].ra, rd);
            check("register", rd, rows[i].exp);
        end
        // unit one on half master clock: period 3 gives 4 ticks of 2 cycles
        i_drt_core_model.io_write(8'h3B, 16'h0003);
        i_drt_core_model.io_write(8'h38, 16'h0400);
        gap(1'b0, 2'h2, w, n);
        check("unit one interval", n[15:0], 16'd8);
        i_drt_core_model.io_write(8'h3A, 16'h0005);
        gap(1'b0, 2'h2, w, n);
        check("old count kept", {15'h0, w <= 6}, 16'h0001);
        check("new period interval", n[15:0], 16'd12);
        i_drt_core_model.io_write(8'h38, 16'h0000);
        i_drt_core_model.io_read(8'h3B, io_hold);
        repeat (10) @(posedge clk);
        i_drt_core_model.io_read(8'h3B, rd);
        check("held count", rd, io_hold);
        // unit two on the reference source: period 2 gives 3 ticks of 10 cycles
        i_drt_core_model.io_write(8'h3F, 16'h0002);
        i_drt_core_model.io_write(8'h38, 16'h0A00);
        gap(1'b1, 2'h3, w, n);
        check("unit two interval", n[15:0], 16'd30);
        i_drt_core_model.io_write(8'h38, 16'h0000);
        // unit one counting comparator events
        i_drt_core_model.io_write(8'h3B, 16'h000A);
        @(posedge clk);
        comp_enable <= 1'b1;
        i_drt_core_model.io_write(8'h38, 16'h0400);
        repeat (4)
        begin
            @(posedge clk);
            comp_tick <= 1'b1;
            @(posedge clk);
            comp_tick <= 1'b0;
        end
        i_drt_core_model.io_write(8'h38, 16'h0000);
        i_drt_core_model.io_read(8'h3B, rd);
        check("comparator count", rd, 16'h0006);
        // zero period with a tick every cycle: a reload on every tick
        i_drt_core_model.io_write(8'h3B, 16'h0000);
        i_drt_core_model.io_write(8'h38, 16'h0400);
        comp_tick <= 1'b1;
        gap(1'b0, 2'h2, w, n);
        check("zero period interval", n[15:0], 16'd1);
        @(posedge clk);
        comp_tick <= 1'b0;
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check_zero();
        test_done();
    end
endmodule

`default_nettype wire
